// ===== fpim_defines.svh
/*
 * Constants of the process image block: widths, region and word
 * offsets, control and status bit positions, reset values.
 * Assumes inclusion by bare name from the package and the modules.
 */
`ifndef FPIM_DEFINES_SVH
`define FPIM_DEFINES_SVH

// Data widths
`define FPIM_WORD_W 16
`define FPIM_BYTE_W 8
`define FPIM_BUS_W 32
`define FPIM_CNT_W 32
`define FPIM_LANE_W 2

// Address regions, bits 7:6 of the byte address
`define FPIM_RGN_IN 2'h0
`define FPIM_RGN_OUT 2'h1
`define FPIM_RGN_CTL 2'h2

// Word offsets inside the single-channel input module area
`define FPIM_SIG_OFS 4'h0
`define FPIM_REF_OFS 4'h1

// Word offsets inside the counter area, and its size
`define FPIM_CNT_CS 4'h0
`define FPIM_CNT_LO 4'h1
`define FPIM_CNT_HI 4'h2
`define FPIM_CNT_WORDS 4'h3

// Interrupt words in the control region
`define FPIM_IRQ_STS 4'h0
`define FPIM_IRQ_MSK 4'h1

// Control byte bits
`define FPIM_CTL_LOAD 0
`define FPIM_CTL_DOWN 1

// Counter status byte bits
`define FPIM_STS_OVF 0
`define FPIM_STS_UNF 1
`define FPIM_STS_ACK 2

// Interrupt event bits
`define FPIM_EVT_OVF 0
`define FPIM_EVT_UNF 1
`define FPIM_EVT_DIN 2
`define FPIM_EVT_W 3

// Reset values
`define FPIM_AO_RST 16'h0000
`define FPIM_AO_CS 8'h00
`define FPIM_BYTE_RST 8'h00
`define FPIM_SET_RST 32'h0000_0000
`define FPIM_EVT_RST 3'h0

`endif

// ===== fpim_pkg.sv
/*
 * Types shared by the process image block: bus request, address
 * layout, analog channel record and bus handshake states.
 * Assumes fpim_defines.svh is on the include path.
 */
`default_nettype none
`include "fpim_defines.svh"

package fpim_pkg;

    // Byte address split into region, image word and byte lane
    typedef struct packed {
        logic [1:0] region;
        logic [3:0] word;
        logic [`FPIM_LANE_W-1:0] lane;
    } fpim_addr_type;

    // Avalon-MM request from the master
    typedef struct packed {
        fpim_addr_type address;
        logic read;
        logic write;
        logic [`FPIM_BUS_W-1:0] writedata;
        logic [3:0] byteenable;
    } fpim_avm_req_type;

    // One analog channel: 16-bit value and 8-bit control/status
    typedef struct packed {
        logic [`FPIM_WORD_W-1:0] value;
        logic [`FPIM_BYTE_W-1:0] ctlStat;
    } fpim_ana_type;

    // Bus handshake states
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } fpim_bus_type;

endpackage : fpim_pkg

`default_nettype wire

// ===== fpim_counter.sv
/*
 * Counter behind the specialty module words: counts pulse edges up or
 * down, loads a setting on a control edge, reports range status.
 * Assumes countLevel is already synchronised to clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fpim_defines.svh"

module fpim_counter
    import fpim_pkg::*;
#(
    parameter int CNT_W = `FPIM_CNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Count source and control
    input wire logic countLevel,
    input wire logic [`FPIM_BYTE_W-1:0] ctrlByte,
    input wire logic [CNT_W-1:0] setting,
    // Results
    output logic [CNT_W-1:0] count_q,
    output logic [`FPIM_BYTE_W-1:0] statusByte,
    output logic overflowEvt,
    output logic underflowEvt
);

    logic cntPrev_q, loadPrev_q, ovf_q, unf_q, ack_q;
    logic [CNT_W-1:0] count_d;
    wire cntEdge = countLevel & ~cntPrev_q;
    wire loadEdge = ctrlByte[`FPIM_CTL_LOAD] & ~loadPrev_q;
    wire countDown = ctrlByte[`FPIM_CTL_DOWN];

    // Wrap detection; a load in the same cycle wins over the count
    assign overflowEvt = cntEdge & ~loadEdge & ~countDown & (&count_q);
    assign underflowEvt = cntEdge & ~loadEdge & countDown & ~(|count_q);

    // Next count: load the setting, else step by one
    always_comb begin
        count_d = count_q;
        if (loadEdge) begin
            count_d = setting;
        end else if (cntEdge) begin
            count_d = countDown ? CNT_W'(count_q - 1'b1) : CNT_W'(count_q + 1'b1);
        end
    end

    // Range flags stay until the next load; a load clears them even with a count edge in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_q <= '0;
            cntPrev_q <= 1'b0;
            loadPrev_q <= 1'b0;
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            count_q <= count_d;
            cntPrev_q <= countLevel;
            loadPrev_q <= ctrlByte[`FPIM_CTL_LOAD];
            ovf_q <= overflowEvt | (ovf_q & ~loadEdge);
            unf_q <= underflowEvt | (unf_q & ~loadEdge);
            ack_q <= ctrlByte[`FPIM_CTL_LOAD] & (ack_q | loadEdge);
        end
    end

    // Status byte toward the control system
    always_comb begin
        statusByte = '0;
        statusByte[`FPIM_STS_OVF] = ovf_q;
        statusByte[`FPIM_STS_UNF] = unf_q;
        statusByte[`FPIM_STS_ACK] = ack_q;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_ctr_load: assert property (loadEdge |=> count_q == $past(setting))
        else $error("counter did not take the setting on load");
    a_ctr_wrap: assert property (overflowEvt |=> count_q == '0 && ovf_q
                                 ##1 (ovf_q || $past(loadEdge)))
        else $error("overflow did not wrap or flag");

endmodule : fpim_counter

`default_nettype wire

// ===== fpim_process_image.sv
/*
 * Process image of a fieldbus node seen over Avalon-MM: analog and
 * digital input words, analog and digital output words, one 32-bit
 * counter module, and an interrupt status/mask pair.
 * Assumes analog values come from logic on clk; pins are synchronised.
 */
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "fpim_defines.svh"

module fpim_process_image
    import fpim_pkg::*;
#(
    parameter int AI_CH = 4,
    parameter int AO_CH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire fpim_avm_req_type avmReq,
    output logic [`FPIM_BUS_W-1:0] readdata,
    output logic waitrequest,
    // Analog input modules
    input wire fpim_ana_type [AI_CH-1:0] aiMulti,
    input wire fpim_ana_type aiSignal,
    input wire fpim_ana_type aiReference,
    // Analog output module
    output fpim_ana_type [AO_CH-1:0] aoChan,
    // Digital input/output module
    input wire logic [`FPIM_BYTE_W-1:0] digitalInputChannel,
    output logic [`FPIM_BYTE_W-1:0] digitalOutputChannel,
    // Counter module pulse pin
    input wire logic countPulse,
    // Interrupt
    output logic irq
);

    localparam int WW = `FPIM_WORD_W;
    localparam int BW = `FPIM_BYTE_W;

    // Image layout: analog words first, then counter, then digital
    localparam logic [3:0] IN_AI = 4'h0;
    localparam logic [3:0] IN_ONE = 4'(AI_CH);
    localparam logic [3:0] IN_CNT = 4'(IN_ONE + `FPIM_REF_OFS + 1);
    localparam logic [3:0] IN_DI = 4'(IN_CNT + `FPIM_CNT_WORDS);
    localparam logic [3:0] OUT_AO = 4'h0;
    localparam logic [3:0] OUT_CNT = 4'(AO_CH);
    localparam logic [3:0] OUT_DO = 4'(OUT_CNT + `FPIM_CNT_WORDS);

    // Address match against one region and one image word
    function automatic logic fpimHit(input fpim_addr_type a, input logic [1:0] rg,
                                     input logic [3:0] w);
        return (a.region == rg) && (a.word == w);
    endfunction : fpimHit

    // Byte-lane merge of a 16-bit image word, lane 0 is the low byte
    function automatic logic [WW-1:0] fpimMerge(input logic [WW-1:0] old,
                                                input logic [WW-1:0] wd,
                                                input logic [1:0] be);
        return {be[1] ? wd[WW-1:BW] : old[WW-1:BW], be[0] ? wd[BW-1:0] : old[BW-1:0]};
    endfunction : fpimMerge

    fpim_addr_type adr;
    fpim_bus_type busState_q, busState_d;
    logic [`FPIM_BUS_W-1:0] rdMux, readData_q;
    logic [WW-1:0] aoVal_q [AO_CH];
    logic [BW-1:0] ctrl_q, doOut_q, cntStatus;
    logic [`FPIM_CNT_W-1:0] setting_q, cntValue;
    logic [BW-1:0] diMeta_q, diSync_q, diPrev_q;
    logic cntMeta_q, cntSync_q, ovfEvt, unfEvt;
    logic [`FPIM_EVT_W-1:0] evt, evtSts_q, evtMsk_q, stsClr;
    logic wrTake, rdTake, lowLane;
    logic [BW-1:0] dataByteZero, dataByteOne, dataByteTwo, dataByteThree;

    assign adr = avmReq.address;

    // Two flip-flops on every pin before any logic looks at it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            diMeta_q <= `FPIM_BYTE_RST;
            diSync_q <= `FPIM_BYTE_RST;
            diPrev_q <= `FPIM_BYTE_RST;
            cntMeta_q <= 1'b0;
            cntSync_q <= 1'b0;
        end else begin
            diMeta_q <= digitalInputChannel;
            diSync_q <= diMeta_q;
            diPrev_q <= diSync_q;
            cntMeta_q <= countPulse;
            cntSync_q <= cntMeta_q;
        end
    end

    // Handshake: one wait cycle, read data registered, write on release
    assign waitrequest = (avmReq.read | avmReq.write) & (busState_q == BUS_IDLE);
    assign rdTake = avmReq.read & (busState_q == BUS_IDLE);
    assign wrTake = avmReq.write & (busState_q == BUS_ACK);
    assign lowLane = avmReq.byteenable[0];

    always_comb begin
        case (busState_q)
            BUS_IDLE: busState_d = (avmReq.read | avmReq.write) ? BUS_ACK : BUS_IDLE;
            BUS_ACK: busState_d = BUS_IDLE;
            default: busState_d = BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busState_q <= BUS_IDLE;
            readData_q <= '0;
        end else begin
            busState_q <= busState_d;
            if (rdTake) begin
                readData_q <= rdMux;
            end
        end
    end
    assign readdata = readData_q;

    // Counter value split into its four data bytes, low byte first
    assign dataByteZero = cntValue[BW-1:0];
    assign dataByteOne = cntValue[WW-1:BW];
    assign dataByteTwo = cntValue[WW+BW-1:WW];
    assign dataByteThree = cntValue[`FPIM_CNT_W-1:WW+BW];

    // Read decode; analog control/status fields are never selected
    always_comb begin
        rdMux = '0;
        for (int i = 0; i < AI_CH; i++) begin
            if (fpimHit(adr, `FPIM_RGN_IN, 4'(IN_AI + i))) begin
                rdMux[WW-1:0] = aiMulti[i].value;
            end
        end
        for (int i = 0; i < AO_CH; i++) begin
            if (fpimHit(adr, `FPIM_RGN_OUT, 4'(OUT_AO + i))) begin
                rdMux[WW-1:0] = aoVal_q[i];
            end
        end
        if (fpimHit(adr, `FPIM_RGN_IN, 4'(IN_ONE + `FPIM_SIG_OFS))) begin
            rdMux[WW-1:0] = aiSignal.value;
        end else if (fpimHit(adr, `FPIM_RGN_IN, 4'(IN_ONE + `FPIM_REF_OFS))) begin
            rdMux[WW-1:0] = aiReference.value;
        end else if (fpimHit(adr, `FPIM_RGN_IN, 4'(IN_CNT + `FPIM_CNT_CS))) begin
            rdMux[BW-1:0] = cntStatus;
        end else if (fpimHit(adr, `FPIM_RGN_IN, 4'(IN_CNT + `FPIM_CNT_LO))) begin
            rdMux[WW-1:0] = {dataByteOne, dataByteZero};
        end else if (fpimHit(adr, `FPIM_RGN_IN, 4'(IN_CNT + `FPIM_CNT_HI))) begin
            rdMux[WW-1:0] = {dataByteThree, dataByteTwo};
        end else if (fpimHit(adr, `FPIM_RGN_IN, IN_DI)) begin
            rdMux[BW-1:0] = diSync_q;
        end else if (fpimHit(adr, `FPIM_RGN_OUT, 4'(OUT_CNT + `FPIM_CNT_CS))) begin
            rdMux[BW-1:0] = ctrl_q;
        end else if (fpimHit(adr, `FPIM_RGN_OUT, 4'(OUT_CNT + `FPIM_CNT_LO))) begin
            rdMux[WW-1:0] = setting_q[WW-1:0];
        end else if (fpimHit(adr, `FPIM_RGN_OUT, 4'(OUT_CNT + `FPIM_CNT_HI))) begin
            rdMux[WW-1:0] = setting_q[`FPIM_CNT_W-1:WW];
        end else if (fpimHit(adr, `FPIM_RGN_OUT, OUT_DO)) begin
            rdMux[BW-1:0] = doOut_q;
        end else if (fpimHit(adr, `FPIM_RGN_CTL, `FPIM_IRQ_STS)) begin
            rdMux[`FPIM_EVT_W-1:0] = evtSts_q;
        end else if (fpimHit(adr, `FPIM_RGN_CTL, `FPIM_IRQ_MSK)) begin
            rdMux[`FPIM_EVT_W-1:0] = evtMsk_q;
        end
    end

    // Analog output words, one register per channel, byte lanes honoured
    for (genvar g = 0; g < AO_CH; g++) begin : g_ao
        wire aoWr = wrTake && fpimHit(adr, `FPIM_RGN_OUT, 4'(OUT_AO + g));
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                aoVal_q[g] <= `FPIM_AO_RST;
            end else if (aoWr) begin
                aoVal_q[g] <= fpimMerge(aoVal_q[g], avmReq.writedata[WW-1:0],
                                        avmReq.byteenable[1:0]);
            end
        end
        // Module record: value from the image, control/status held fixed
        assign aoChan[g] = {aoVal_q[g], `FPIM_AO_CS};
    end

    // Write strobes for the counter, digital and interrupt words
    wire ctrlWr = wrTake && lowLane && fpimHit(adr, `FPIM_RGN_OUT, 4'(OUT_CNT + `FPIM_CNT_CS));
    wire setLoWr = wrTake && fpimHit(adr, `FPIM_RGN_OUT, 4'(OUT_CNT + `FPIM_CNT_LO));
    wire setHiWr = wrTake && fpimHit(adr, `FPIM_RGN_OUT, 4'(OUT_CNT + `FPIM_CNT_HI));
    wire doWr = wrTake && lowLane && fpimHit(adr, `FPIM_RGN_OUT, OUT_DO);
    wire mskWr = wrTake && lowLane && fpimHit(adr, `FPIM_RGN_CTL, `FPIM_IRQ_MSK);
    wire stsWr = wrTake && lowLane && fpimHit(adr, `FPIM_RGN_CTL, `FPIM_IRQ_STS);

    // Control byte lives in the low lane; the high lane is dropped
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= `FPIM_BYTE_RST;
            doOut_q <= `FPIM_BYTE_RST;
            setting_q <= `FPIM_SET_RST;
        end else begin
            if (ctrlWr) begin
                ctrl_q <= avmReq.writedata[BW-1:0];
            end
            if (doWr) begin
                doOut_q <= avmReq.writedata[BW-1:0];
            end
            if (setLoWr) begin
                setting_q[WW-1:0] <= fpimMerge(setting_q[WW-1:0],
                                               avmReq.writedata[WW-1:0],
                                               avmReq.byteenable[1:0]);
            end
            if (setHiWr) begin
                setting_q[`FPIM_CNT_W-1:WW] <= fpimMerge(setting_q[`FPIM_CNT_W-1:WW],
                                                         avmReq.writedata[WW-1:0],
                                                         avmReq.byteenable[1:0]);
            end
        end
    end
    assign digitalOutputChannel = doOut_q;

    // Counter module; its status byte feeds the input image
    fpim_counter #(
        .CNT_W(`FPIM_CNT_W)
    ) fpim_counter_i (
        .clk(clk),
        .sys_rst(sys_rst),
        .countLevel(cntSync_q),
        .ctrlByte(ctrl_q),
        .setting(setting_q),
        .count_q(cntValue),
        .statusByte(cntStatus),
        .overflowEvt(ovfEvt),
        .underflowEvt(unfEvt)
    );

    // Events: counter wraps and any change on the digital inputs
    always_comb begin
        evt = '0;
        evt[`FPIM_EVT_OVF] = ovfEvt;
        evt[`FPIM_EVT_UNF] = unfEvt;
        evt[`FPIM_EVT_DIN] = |(diSync_q ^ diPrev_q);
    end
    assign stsClr = stsWr ? avmReq.writedata[`FPIM_EVT_W-1:0] : '0;

    // Sticky status, write one to clear; a new event beats its clear
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            evtSts_q <= `FPIM_EVT_RST;
            evtMsk_q <= `FPIM_EVT_RST;
        end else begin
            evtSts_q <= evt | (evtSts_q & ~stsClr);
            if (mskWr) begin
                evtMsk_q <= avmReq.writedata[`FPIM_EVT_W-1:0];
            end
        end
    end
    assign irq = |(evtSts_q & evtMsk_q);

    // Checks on the bus and image behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_take(logic [1:0] rg, logic [3:0] w);
        rdTake && fpimHit(adr, rg, w);
    endsequence

    sequence s_answer;
        !waitrequest && busState_q == BUS_ACK;
    endsequence

    sequence s_write(logic [1:0] rg, logic [3:0] w);
        wrTake && avmReq.byteenable[1:0] == 2'h3 && fpimHit(adr, rg, w);
    endsequence

    a_wait_one: assert property ((avmReq.read || avmReq.write) && busState_q == BUS_IDLE
                                 |-> waitrequest ##1 s_answer)
        else $error("bus answer not after exactly one wait cycle");
    a_ai_read: assert property (s_take(`FPIM_RGN_IN, IN_AI) |=> s_answer
                                ##0 readdata == {16'h0000, $past(aiMulti[0].value)})
        else $error("first analog input word wrong");
    a_ref_read: assert property (s_take(`FPIM_RGN_IN, 4'(IN_ONE + `FPIM_REF_OFS))
                                 |=> readdata[WW-1:0] == $past(aiReference.value))
        else $error("reference value not at word one");
    a_sig_read: assert property (s_take(`FPIM_RGN_IN, 4'(IN_ONE + `FPIM_SIG_OFS))
                                 |=> readdata == {16'h0000, $past(aiSignal.value)})
        else $error("signal value not at word zero");
    a_di_read: assert property (s_take(`FPIM_RGN_IN, IN_DI)
                                |=> readdata == {24'h000000, $past(diSync_q)})
        else $error("digital input byte misplaced");
    a_cs_low: assert property (s_take(`FPIM_RGN_IN, 4'(IN_CNT + `FPIM_CNT_CS))
                               |=> readdata[`FPIM_BUS_W-1:BW] == '0
                               && readdata[BW-1:0] == $past(cntStatus))
        else $error("status byte not alone in low byte");
    a_cnt_low: assert property (s_take(`FPIM_RGN_IN, 4'(IN_CNT + `FPIM_CNT_LO))
                                |=> readdata == {16'h0000, $past(cntValue[WW-1:0])})
        else $error("counter low word wrong");
    a_cnt_high: assert property (s_take(`FPIM_RGN_IN, 4'(IN_CNT + `FPIM_CNT_HI))
                                 |=> readdata[WW-1:0] == $past(cntValue[`FPIM_CNT_W-1:WW]))
        else $error("counter high word wrong");
    a_ctl_spare: assert property (s_take(`FPIM_RGN_OUT, 4'(OUT_CNT + `FPIM_CNT_CS))
                                  |=> readdata[`FPIM_BUS_W-1:BW] == '0
                                  && readdata[BW-1:0] == $past(ctrl_q))
        else $error("control word spare byte not zero");
    a_do_write: assert property (doWr
                                 |=> digitalOutputChannel == $past(avmReq.writedata[BW-1:0])
                                 ##1 $stable(digitalOutputChannel))
        else $error("digital output byte not applied");
    a_ao_write: assert property (s_write(`FPIM_RGN_OUT, OUT_AO)
                                 |=> aoChan[0].value == $past(avmReq.writedata[WW-1:0]))
        else $error("analog output word not applied");
    a_set_high: assert property (s_write(`FPIM_RGN_OUT, 4'(OUT_CNT + `FPIM_CNT_HI))
                                 |=> setting_q[`FPIM_CNT_W-1:WW]
                                 == $past(avmReq.writedata[WW-1:0]))
        else $error("setting high word not applied");
    a_ctl_high: assert property (ctrlWr |=> ctrl_q == $past(avmReq.writedata[BW-1:0]))
        else $error("control byte not taken from low lane");
    a_set_wins: assert property (ovfEvt && stsClr[`FPIM_EVT_OVF]
                                 |=> evtSts_q[`FPIM_EVT_OVF])
        else $error("event lost against its clear");
    a_sts_clear: assert property (stsWr && evt == '0
                                  |=> (evtSts_q & $past(stsClr)) == '0)
        else $error("write one did not clear status");
    a_mask_write: assert property (mskWr
                                   |=> evtMsk_q == $past(avmReq.writedata[`FPIM_EVT_W-1:0]))
        else $error("mask write not applied");
    a_irq_level: assert property ((evt & evtMsk_q) != '0 && !mskWr |=> irq)
        else $error("unmasked event did not raise the interrupt");

endmodule : fpim_process_image

`default_nettype wire

// ===== fpim_host_model.sv
/*
 * Control system model: an Avalon-MM master issuing one word request at a time.
 * Assumes the slave answers with waitrequest low and holds readdata meanwhile.
 */
`timescale 1ns/10ps
`default_nettype none
module fpim_host_model
    import fpim_pkg::*;
(
    // Bus
    input wire logic clk,
    output fpim_avm_req_type avmReq,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    initial avmReq = '0;

    // Request held until waitrequest is sampled low at a rising edge; no cycle count assumed
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        avmReq.address <= fpim_addr_type'(a);
        avmReq.read <= !wr;
        avmReq.write <= wr;
        avmReq.writedata <= wd;
        avmReq.byteenable <= 4'h3;
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rd = readdata;
        avmReq.read <= 1'b0;
        avmReq.write <= 1'b0;
        // One idle edge so the next request never lands in the same step
        @(posedge clk);
    endtask : xfer
endmodule : fpim_host_model
`default_nettype wire

// ===== fpim_process_image_tb.sv
/*
 * Self-checking bench of the process image: random analog and digital data,
 * counter load and wrap, interrupt status, mask and clear.
 * Assumes the default of four analog input and four analog output channels.
 */
`timescale 1ns/10ps
`default_nettype none
module fpim_process_image_tb;
    import fpim_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    fpim_avm_req_type avmReq;
    logic [31:0] readdata, rd, s;
    logic [31:0] v [4];
    logic waitrequest, countPulse = 1'b0, irq;
    fpim_ana_type [3:0] aiMulti = '0, aoChan;
    fpim_ana_type aiSignal = '0, aiReference = '0;
    logic [7:0] dIn = 8'h00, dOut;
    int errorCnt = 0, checked = 0;

    fpim_host_model fpim_host_model_i (.clk(clk), .avmReq(avmReq), .readdata(readdata),
        .waitrequest(waitrequest));
    fpim_process_image #(.AI_CH(4), .AO_CH(4)) fpim_process_image_i (.clk(clk),
        .sys_rst(sys_rst), .avmReq(avmReq), .readdata(readdata), .waitrequest(waitrequest),
        .aiMulti(aiMulti), .aiSignal(aiSignal), .aiReference(aiReference), .aoChan(aoChan),
        .digitalInputChannel(dIn), .digitalOutputChannel(dOut), .countPulse(countPulse),
        .irq(irq));

    // Clock
    initial forever #2 clk = ~clk;

    // Byte address of an image word
    function automatic logic [7:0] adr(input logic [1:0] r, input logic [3:0] w);
        return {r, w, 2'b00};
    endfunction : adr

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errorCnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        fpim_host_model_i.xfer(1'b1, a, d, rd);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        fpim_host_model_i.xfer(1'b0, a, 32'h0, rd);
        chk(rd, exp);
    endtask : rdc

    task automatic print_verdict();
        $display("checked %0d errorCnt %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // Watchdog, far beyond the under two hundred cycles of the sequence
    initial begin
        #100000;
        errorCnt++;
        print_verdict();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h86848ce5));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk({readdata[23:0], dOut}, 32'h0);
        chk({aoChan[0], irq}, 32'h0);
        // Random inputs, control/status bytes included so leaks show
        for (int i = 0; i < 4; i++) aiMulti[i] <= fpim_ana_type'(24'($urandom));
        aiSignal <= fpim_ana_type'(24'($urandom));
        aiReference <= fpim_ana_type'(24'($urandom));
        dIn <= 8'(($urandom % 8'hff) + 8'h01);
        repeat (6) @(posedge clk);
        for (int i = 0; i < 4; i++) rdc(adr(2'h0, 4'(i)), aiMulti[i].value);
        rdc(adr(2'h0, 4'h4), aiSignal.value);
        rdc(adr(2'h0, 4'h5), aiReference.value);
        rdc(adr(2'h0, 4'h9), dIn);
        // Input image is read-only, unmapped reads give zero
        wr(adr(2'h0, 4'h9), ~dIn);
        rdc(adr(2'h0, 4'h9), dIn);
        rdc(adr(2'h2, 4'h3), 32'h0);
        for (int i = 0; i < 4; i++) begin
            v[i] = $urandom;
            wr(adr(2'h1, 4'(i)), v[i]);
        end
        for (int i = 0; i < 4; i++) chk(aoChan[i], {v[i][15:0], 8'h00});
        wr(adr(2'h1, 4'h7), v[0]);
        chk(dOut, v[0][7:0]);
        // Counter load at the top of the range, high control byte is junk
        s = 32'hffff_ffff;
        wr(adr(2'h1, 4'h5), s[15:0]);
        wr(adr(2'h1, 4'h6), s[31:16]);
        wr(adr(2'h1, 4'h4), 32'h0000_ff01);
        rdc(adr(2'h0, 4'h7), s[15:0]);
        rdc(adr(2'h0, 4'h8), s[31:16]);
        rdc(adr(2'h0, 4'h6), 32'h4);
        // One pulse wraps the count and flags overflow
        countPulse <= 1'b1;
        repeat (6) @(posedge clk);
        countPulse <= 1'b0;
        rdc(adr(2'h0, 4'h7), 32'h0);
        rdc(adr(2'h0, 4'h6), 32'h5);
        // Overflow and input change are pending but masked
        rdc(8'h80, 32'h5);
        chk(irq, 1'b0);
        wr(8'h84, 32'h1);
        chk(irq, 1'b1);
        wr(8'h80, 32'h5);
        chk(irq, 1'b0);
        rdc(8'h80, 32'h0);
        // Count down from zero: the wrap sets underflow, masked off from the interrupt
        wr(adr(2'h1, 4'h5), 32'h0);
        wr(adr(2'h1, 4'h6), 32'h0);
        wr(adr(2'h1, 4'h4), 32'h0000_0002);
        rdc(adr(2'h0, 4'h6), 32'h1);
        wr(adr(2'h1, 4'h4), 32'h0000_0003);
        rdc(adr(2'h0, 4'h6), 32'h4);
        countPulse <= 1'b1;
        repeat (6) @(posedge clk);
        countPulse <= 1'b0;
        rdc(adr(2'h0, 4'h8), 32'hffff);
        rdc(adr(2'h0, 4'h6), 32'h6);
        rdc(8'h80, 32'h2);
        chk(irq, 1'b0);
        print_verdict();
    end
endmodule : fpim_process_image_tb
`default_nettype wire
